// ==== hw/lps_scan_seq.sv ====
// Scan and integration sequencer of a linear pixel sensor.
// Assumes the sensor clock, start and hold pins arrive asynchronously;
// the integrator levels on pixel_level_in are on the mclk_in domain.
//
// Overview of operation
// - Start sampled high on a sensor clock edge begins readout and setup.
// - Hold freezes all pixel samples; start shows pixel 1 at once.
// - Each further clock moves the output on to the next pixel.
// - Integrators held in reset for the start and 17 more clocks.
// - Clock 19 releases every integrator reset together.
// - Pixels 1 to 18 read during reset, resume sampling on clock 19.
// - From pixel 19, each pixel resumes sampling the clock after reading.
// - Clock n+1 returns the last pixel to sampling, output goes idle.
// - Integration time is start-to-hold span minus 18 setup clocks.
// - Previous exposure is read while the next one integrates.
// - Each pixel value stands for a whole sensor clock period.
// - Pixel count n is 128.
`timescale 1ns/1ns
`include "lps_consts.svh"

module lps_scan_seq
   import lps_pkg::*;
#(
   parameter int N  = `LPS_PIXEL_COUNT,
   parameter int DW = `LPS_DATA_W
) (
   input  wire logic              mclk_in,
   input  wire logic              reset_in,
   input  wire logic              sensor_clk_in,
   input  wire logic              start_in,
   input  wire logic              hold_in,
   input  wire logic [N*DW-1:0]   pixel_level_in,
   output logic      [DW-1:0]     analog_pixel_out,
   output logic                   analog_out_en_out,
   output logic      [`LPS_IDX_W-1:0] pixel_index_out,
   output logic                   integrator_reset_switch_out,
   output logic      [N-1:0]      sample_select_switch_out
);

   localparam int CW = `LPS_CNT_W;
   localparam int IW = `LPS_IDX_W;
   localparam logic [CW-1:0] LAST_PIX  = CW'(N);
   localparam logic [CW-1:0] END_CLK   = CW'(N + 1);
   localparam logic [CW-1:0] SETUP_CLK = CW'(`LPS_SETUP_CLOCKS);
   localparam logic [CW-1:0] REL_CLK   = CW'(`LPS_RELEASE_CLOCK);

   logic [`LPS_PIN_COUNT-1:0] pins_s;
   logic                      sclk_s;
   logic                      start_s;
   logic                      hold_s;
   logic                      sclk_prev_q;
   logic                      sclk_rise;
   logic                      start_take;
   logic                      hold_take;
   logic                      advance;
   logic [CW-1:0]             cnt_q;
   logic [CW-1:0]             cnt_nx;
   lps_state_t                state_q;
   logic [DW-1:0]             samp_q [N];
   logic [DW-1:0]             sel_val;

   function automatic logic [CW-1:0] next_count(input logic [CW-1:0] c);
      next_count = CW'(c + 1'b1);
   endfunction

   function automatic logic [IW-1:0] pix_of(input logic [CW-1:0] c);
      pix_of = IW'(c - 1'b1);
   endfunction

   // ==========================================================
   // Pin synchronisation and sensor clock edge
   lps_sync #(
      .W(`LPS_PIN_COUNT)
   ) u_sync (
      .mclk_in (mclk_in),
      .reset_in(reset_in),
      .pin_in  ({hold_in, start_in, sensor_clk_in}),
      .sync_out(pins_s)
   );

   assign sclk_s  = pins_s[0];
   assign start_s = pins_s[1];
   assign hold_s  = pins_s[2];

   // Start and hold share the clock's latency, so setup margin holds
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         sclk_prev_q <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_s;
      end
   end

   assign sclk_rise  = sclk_s & ~sclk_prev_q;
   assign start_take = sclk_rise & start_s;
   assign hold_take  = sclk_rise & hold_s;
   assign advance    = sclk_rise & ~start_s & (state_q != LPS_ST_IDLE);
   assign cnt_nx     = next_count(cnt_q);

   // ==========================================================
   // Clock counter and state
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         cnt_q   <= '0;
         state_q <= LPS_ST_IDLE;
      end else if (start_take) begin
         cnt_q   <= `LPS_FIRST_COUNT;
         state_q <= LPS_ST_SETUP;
      end else if (advance) begin
         cnt_q <= cnt_nx;
         case (state_q)
            LPS_ST_SETUP: begin
               if (cnt_nx == REL_CLK) begin
                  state_q <= LPS_ST_READ;
               end
            end
            LPS_ST_READ: begin
               if (cnt_nx == END_CLK) begin
                  state_q <= LPS_ST_IDLE;
               end
            end
            default: begin
               state_q <= LPS_ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Integrator reset switch
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         integrator_reset_switch_out <= 1'b0;
      end else if (start_take) begin
         integrator_reset_switch_out <= 1'b1;
      end else if (advance && cnt_nx == REL_CLK) begin
         integrator_reset_switch_out <= 1'b0;
      end
   end

   // ==========================================================
   // Output pixel select and drive enable
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         pixel_index_out   <= '0;
         analog_out_en_out <= 1'b0;
      end else if (start_take) begin
         pixel_index_out   <= '0;
         analog_out_en_out <= 1'b1;
      end else if (advance) begin
         if (cnt_nx <= LAST_PIX) begin
            pixel_index_out <= pix_of(cnt_nx);
         end else if (cnt_nx == END_CLK) begin
            analog_out_en_out <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Sample select switches, one per pixel
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         sample_select_switch_out <= '1;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (hold_take) begin
               sample_select_switch_out[i] <= 1'b0;
            end else if (advance) begin
               if (cnt_nx == REL_CLK && i < `LPS_SETUP_CLOCKS) begin
                  sample_select_switch_out[i] <= 1'b1;
               end
               if (cnt_nx > REL_CLK && cnt_nx <= END_CLK
                   && CW'(i) == CW'(cnt_nx - `LPS_RESUME_LAG)) begin
                  sample_select_switch_out[i] <= 1'b1;
               end
            end
         end
      end
   end

   // ==========================================================
   // Sample stage: tracks its integrator only while selected
   // held data read as next exposure integrates
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         for (int i = 0; i < N; i++) begin
            samp_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < N; i++) begin
            if (sample_select_switch_out[i] && !hold_take) begin
               samp_q[i] <= integrator_reset_switch_out ? '0 :
                            pixel_level_in[i*DW +: DW];
            end
         end
      end
   end

   assign sel_val = samp_q[pixel_index_out];

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         analog_pixel_out <= '0;
      end else begin
         analog_pixel_out <= analog_out_en_out ? sel_val : '0;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);

   start_restart_a: assert property (start_take |=>
      cnt_q == `LPS_FIRST_COUNT && state_q == LPS_ST_SETUP
      && analog_out_en_out && pixel_index_out == '0)
      else $error("start did not restart the scan");

   hold_freeze_a: assert property (hold_take |=>
      sample_select_switch_out == '0)
      else $error("hold did not freeze all samples");

   pixel_step_a: assert property (advance && cnt_q < LAST_PIX |=>
      pixel_index_out == IW'($past(pixel_index_out) + 1'b1))
      else $error("output pixel did not advance by one");

   reset_span_a: assert property (integrator_reset_switch_out |->
      cnt_q <= SETUP_CLK && state_q == LPS_ST_SETUP)
      else $error("integrator reset outside setup clocks");

   reset_release_a: assert property (advance && cnt_q == SETUP_CLK |=>
      !integrator_reset_switch_out && state_q == LPS_ST_READ)
      else $error("integrator reset not released on clock 19");

   early_resume_a: assert property (
      advance && cnt_q == SETUP_CLK && !hold_take |=>
      &sample_select_switch_out[`LPS_SETUP_CLOCKS-1:0])
      else $error("first pixels not sampling on clock 19");

   late_resume_a: assert property (
      advance && cnt_q == REL_CLK && !hold_take |=>
      sample_select_switch_out[`LPS_SETUP_CLOCKS]
      && !$past(sample_select_switch_out[`LPS_SETUP_CLOCKS+1]) ==
         !sample_select_switch_out[`LPS_SETUP_CLOCKS+1])
      else $error("pixel 19 not sampling on clock 20");

   scan_end_a: assert property (
      advance && cnt_q == LAST_PIX && !hold_take |=>
      !analog_out_en_out && state_q == LPS_ST_IDLE
      && sample_select_switch_out[N-1])
      else $error("scan end did not release output");

   held_stable_a: assert property (
      !sample_select_switch_out[0] |=> $stable(samp_q[0]))
      else $error("held sample changed while not sampling");

   out_value_a: assert property (analog_out_en_out |=>
      analog_pixel_out == $past(sel_val))
      else $error("output does not show the selected pixel");

   idle_quiet_a: assert property (
      state_q == LPS_ST_IDLE && !start_take |=> !analog_out_en_out)
      else $error("output driven while idle");

   // Setup and read must never disagree on the integrator switch
   setup_reset_a: assert property (
      state_q == LPS_ST_SETUP |-> integrator_reset_switch_out)
      else $error("integrators not held through setup clocks");

   read_integrate_a: assert property (
      state_q == LPS_ST_READ |-> !integrator_reset_switch_out)
      else $error("integrator reset during pixel read");

   // Count never passes the last pixel while the output drives
   count_range_a: assert property (
      state_q != LPS_ST_IDLE |-> cnt_q != '0 && cnt_q <= LAST_PIX)
      else $error("clock count outside the scan");

   // Stray sensor clocks while idle must not move the scan
   idle_still_a: assert property (
      state_q == LPS_ST_IDLE && !start_take |=>
      $stable(cnt_q) && $stable(pixel_index_out))
      else $error("scan moved while idle");

endmodule

// ==== common/lps_consts.svh ====
// Timing and geometry constants of the linear pixel scan sequencer.
// Included by the package and the design files; definitions only.
`ifndef LPS_CONSTS_SVH
`define LPS_CONSTS_SVH

// ==========================================================
// Geometry
`define LPS_PIXEL_COUNT   128
`define LPS_DATA_W        8
`define LPS_CNT_W         8
`define LPS_IDX_W         7

// ==========================================================
// Sequence points, counted in sensor clocks, start edge = 1
`define LPS_FIRST_COUNT   8'h01
`define LPS_SETUP_CLOCKS  18
`define LPS_RELEASE_CLOCK 19
// Clocks from a pixel's read clock to its resume clock, plus one
`define LPS_RESUME_LAG    8'h02

// ==========================================================
// Pin synchroniser
`define LPS_SYNC_STAGES   2
`define LPS_PIN_COUNT     3

`endif

// ==== common/lps_pkg.sv ====
// Types shared by the linear pixel scan sequencer files.
// Assumes lps_consts.svh is on the include path.
`include "lps_consts.svh"

package lps_pkg;

   // ==========================================================
   // Sequencer states
   typedef enum logic [1:0] {
      LPS_ST_IDLE  = 2'b00,
      LPS_ST_SETUP = 2'b01,
      LPS_ST_READ  = 2'b10
   } lps_state_t;

endpackage

// ==== hw/lps_sync.sv ====
// Two-flop synchroniser for a group of pin levels.
// Assumes the pins are independent levels; no bus coherence kept.
`timescale 1ns/1ns
`include "lps_consts.svh"

module lps_sync
   import lps_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         mclk_in,
   input  wire logic         reset_in,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_q;

   // ==========================================================
   // First stage feeds only the second
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= pin_in;
         sync_out <= meta_q;
      end
   end

endmodule

// ==== sim/lps_host_model.sv ====
// Host controller model: sensor clock, start and hold pins.
// Assumes mclk_in is the bench's 100 MHz clock; pins change on its edge.
`timescale 1ns/1ns

module lps_host_model (
   input  wire logic mclk_in,
   output logic      sensor_clk_out,
   output logic      start_out,
   output logic      hold_out
);
   initial begin
      sensor_clk_out = 1'b0;
      start_out      = 1'b0;
      hold_out       = 1'b0;
   end

   // ==========================================================
   // One sensor clock, optionally with a start pulse
   task automatic tick(input logic with_start, input int half);
      @(posedge mclk_in);
      start_out <= with_start;
      hold_out  <= with_start;
      repeat (2) @(posedge mclk_in);
      // half of 4 or more keeps rate under 8 MHz
      sensor_clk_out <= 1'b1;
      repeat (4) @(posedge mclk_in);
      // start low long before next rise
      start_out <= 1'b0;
      hold_out  <= 1'b0;
      repeat (half) @(posedge mclk_in);
      sensor_clk_out <= 1'b0;
      repeat (half) @(posedge mclk_in);
   endtask

   // ==========================================================
   // Quiet time after a full scan
   // charge transfer wait, far below 100 ms
   task automatic settle();
      repeat (2000) @(posedge mclk_in);
   endtask
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench of the scan sequencer with a host model.
// Assumes design files and lps_consts.svh are on the compile path.
`timescale 1ns/1ns
`include "lps_consts.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
   failures++; $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); \
   end end

module tb_top;
   localparam int N  = `LPS_PIXEL_COUNT;
   localparam int DW = `LPS_DATA_W;

   logic                   mclk_in = 1'b0;
   logic                   reset_in;
   logic                   sclk;
   logic                   start;
   logic                   hold;
   logic [N*DW-1:0]        pixel_level_in;
   logic [DW-1:0]          analog;
   logic                   out_en;
   logic [`LPS_IDX_W-1:0]  index;
   logic                   int_rst;
   logic [N-1:0]           selects;
   int                     failures    = 0;
   int                     comparisons = 0;

   always #5 mclk_in = ~mclk_in;

   lps_host_model host (.mclk_in(mclk_in), .sensor_clk_out(sclk),
      .start_out(start), .hold_out(hold));

   lps_scan_seq #(.N(N), .DW(DW)) dut (
      .mclk_in                     (mclk_in),
      .reset_in                    (reset_in),
      .sensor_clk_in               (sclk),
      .start_in                    (start),
      .hold_in                     (hold),
      .pixel_level_in              (pixel_level_in),
      .analog_pixel_out            (analog),
      .analog_out_en_out           (out_en),
      .pixel_index_out             (index),
      .integrator_reset_switch_out (int_rst),
      .sample_select_switch_out    (selects)
   );

   function automatic logic [N*DW-1:0] pattern(input logic [7:0] k);
      logic [N*DW-1:0] p;
      for (int i = 0; i < N; i++) begin
         p[i*DW +: DW] = DW'(i * 5 + k);
      end
      return p;
   endfunction

   task automatic check_idle();
      `CHK("enable", 1'b0, out_en)
      `CHK("analog", {DW{1'b0}}, analog)
      `CHK("int_reset", 1'b0, int_rst)
      `CHK("selects", {N{1'b1}}, selects)
   endtask

   // ==========================================================
   // Start, then clocks up to last; each clock judged
   task automatic run_scan(input logic [N*DW-1:0] exp,
                           input logic [N*DW-1:0] next_lvl,
                           input int half, input int last);
      logic [N-1:0] sel_exp;
      for (int c = 1; c <= last; c++) begin
         host.tick(c == 1, half);
         // Frozen samples must ignore later levels
         if (c == 1) begin
            pixel_level_in <= next_lvl;
         end
         for (int i = 0; i < N; i++) begin
            sel_exp[i] = (c >= 19) && (i < c - 1);
         end
         if (c <= N) begin
            `CHK("enable", 1'b1, out_en)
            `CHK("index", `LPS_IDX_W'(c - 1), index)
            `CHK("analog", exp[(c-1)*DW +: DW], analog)
            `CHK("int_reset", c < 19, int_rst)
            `CHK("selects", sel_exp, selects)
         end else begin
            check_idle();
         end
      end
   endtask

   // ==========================================================
   // Scenarios
   task automatic sc_reset_state();
      check_idle();
      `CHK("index", {`LPS_IDX_W{1'b0}}, index)
   endtask

   task automatic sc_first_scan();
      run_scan(pattern(8'h10), pattern(8'h20), 8, N + 1);
      host.settle();
   endtask

   task automatic sc_idle_clocks();
      for (int k = 0; k < 3; k++) begin
         host.tick(1'b0, 4);
         check_idle();
      end
   endtask

   // Restart mid-scan: pixels 1 to 29 resampled, pixel 30 and on stay held
   task automatic sc_restart();
      logic [N*DW-1:0] mix;
      logic [N*DW-1:0] lvl;
      run_scan(pattern(8'h20), pattern(8'h30), 4, 30);
      mix = pattern(8'h20);
      lvl = pattern(8'h30);
      mix[29*DW-1:0] = lvl[29*DW-1:0];
      run_scan(mix, pattern(8'h40), 4, N + 1);
      host.settle();
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge mclk_in);
      failures++;
      $display("MISMATCH watchdog expected 0 seen 1");
      tally_and_finish();
   end

   initial begin
      reset_in       <= 1'b1;
      pixel_level_in <= pattern(8'h10);
      repeat (12) @(posedge mclk_in);
      reset_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      sc_reset_state();
      sc_first_scan();
      sc_idle_clocks();
      sc_restart();
      tally_and_finish();
   end
endmodule
